/* File: lcd_ctrl_pkg.sv */
// Shared constants, types and helpers for the LCD drive-mode control block
package lcd_ctrl_pkg;

   // ---------------------------------------------------------------
   // Register addresses and reset values
   // ---------------------------------------------------------------
   localparam logic [15:0] DRIVE_SETUP_ADDR = 16'hffb0;
   localparam logic [15:0] DISPLAY_CONTROL_ADDR = 16'hffb1;
   localparam logic [7:0] DRIVE_SETUP_RESET = 8'h00;
   localparam logic [7:0] DISPLAY_CONTROL_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Field positions and writable masks
   // ---------------------------------------------------------------
   localparam int KEY_SCAN_ENABLE_BIT = 0;
   localparam int KEY_SCAN_PHASE_FLAG_BIT = 1;
   localparam int VGEN_SEL_LO_BIT = 4;
   localparam int VGEN_SEL_HI_BIT = 5;
   localparam int DISPLAY_ENABLE_BIT = 7;
   localparam int PIN_OUTPUT_CONTROL_BIT = 6;
   localparam int GATE_BOOST_ENABLE_BIT = 4;
   localparam int MODE_SEL_LSB = 0;
   localparam int MODE_SEL_MSB = 2;
   localparam logic [7:0] DRIVE_SETUP_WMASK = 8'h31;
   localparam logic [7:0] DISPLAY_CONTROL_WMASK = 8'hd7;

   // ---------------------------------------------------------------
   // Codes
   // ---------------------------------------------------------------
   localparam logic [1:0] VGEN_EXTERNAL = 2'h0;
   localparam logic [1:0] VGEN_INT_NO_STEP = 2'h1;
   localparam logic [1:0] VGEN_INT_STEP = 2'h3;
   localparam logic [2:0] MODE_8_QUARTER = 3'h7;
   localparam logic [2:0] MODE_4_THIRD = 3'h0;
   localparam logic [2:0] MODE_3_THIRD = 3'h1;
   localparam logic [2:0] MODE_2_HALF = 3'h2;
   localparam logic [2:0] MODE_3_HALF = 3'h3;
   localparam logic [2:0] MODE_STATIC = 3'h4;
   localparam logic [3:0] SLICES_NONE = 4'h0;
   localparam logic [3:0] SLICES_1 = 4'h1;
   localparam logic [3:0] SLICES_2 = 4'h2;
   localparam logic [3:0] SLICES_3 = 4'h3;
   localparam logic [3:0] SLICES_4 = 4'h4;
   localparam logic [3:0] SLICES_8 = 4'h8;
   localparam logic [7:0] KEY_SOURCE_ALL = 8'hff;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_DISP = 2'b01,
      PH_SCAN = 2'b11
   } slice_phase_e;

   typedef enum logic [1:0] {
      BIAS_STATIC = 2'h0,
      BIAS_HALF = 2'h1,
      BIAS_THIRD = 2'h2,
      BIAS_QUARTER = 2'h3
   } bias_e;

   typedef struct packed {
      logic [15:0] addr;
      logic byte_we;
      logic bit_we;
      logic [2:0] bit_idx;
      logic bit_val;
      logic [7:0] wdata;
   } cpu_wr_s;

   typedef struct packed {
      logic pins_grounded;
      logic seg_deselect;
      logic gate_boost_enable;
      logic [1:0] vgen_sel;
      logic vgen_valid;
      bias_e bias;
      logic mode_valid;
      logic ref3_select;
      logic com_hi_is_common;
   } panel_ctrl_s;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] wr_merge(input logic [7:0] old, input cpu_wr_s wr,
                                           input logic [7:0] mask);
      logic [7:0] v;
      v = old;
      if (wr.byte_we) begin
         v = wr.wdata;
      end else if (wr.bit_we) begin
         v[wr.bit_idx] = wr.bit_val;
      end
      return v & mask;
   endfunction

   function automatic logic [3:0] mode_slices(input logic [2:0] m);
      case (m)
         MODE_8_QUARTER: mode_slices = SLICES_8;
         MODE_4_THIRD: mode_slices = SLICES_4;
         MODE_3_THIRD: mode_slices = SLICES_3;
         MODE_2_HALF: mode_slices = SLICES_2;
         MODE_3_HALF: mode_slices = SLICES_3;
         MODE_STATIC: mode_slices = SLICES_1;
         default: mode_slices = SLICES_NONE;
      endcase
   endfunction

   function automatic bias_e mode_bias(input logic [2:0] m);
      case (m)
         MODE_8_QUARTER: mode_bias = BIAS_QUARTER;
         MODE_4_THIRD, MODE_3_THIRD: mode_bias = BIAS_THIRD;
         MODE_2_HALF, MODE_3_HALF: mode_bias = BIAS_HALF;
         default: mode_bias = BIAS_STATIC;
      endcase
   endfunction

endpackage

/* File: lcd_slice_sequencer.sv */
// Time-slice sequencer: display slices plus optional key-scan slice
`timescale 1ns/1ps
module lcd_slice_sequencer
   import lcd_ctrl_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic tick_i,
   input wire logic run_i,
   input wire logic [3:0] slices_i,
   input wire logic scan_en_i,
   output slice_phase_e phase_o,
   output logic [2:0] com_idx_o,
   output logic scan_end_o
);

   slice_phase_e phase_q;
   slice_phase_e phase_d;
   logic [2:0] idx_q;
   logic [2:0] idx_d;
   logic scan_end_q;

   wire logic last_slice = ({1'b0, idx_q} == (slices_i - SLICES_1));

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      phase_d = phase_q;
      idx_d = idx_q;
      if (!run_i) begin
         phase_d = PH_IDLE;
         idx_d = 3'h0;
      end else if (tick_i) begin
         case (phase_q)
            PH_IDLE: begin
               phase_d = PH_DISP;
               idx_d = 3'h0;
            end
            PH_DISP: begin
               if (!last_slice) begin
                  idx_d = idx_q + 3'h1;
               end else if (scan_en_i) begin
                  phase_d = PH_SCAN;
               end else begin
                  idx_d = 3'h0;
               end
            end
            PH_SCAN: begin
               phase_d = PH_DISP;
               idx_d = 3'h0;
            end
            default: begin
               phase_d = PH_IDLE;
               idx_d = 3'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_q <= PH_IDLE;
         idx_q <= 3'h0;
         scan_end_q <= 1'b0;
      end else begin
         phase_q <= phase_d;
         idx_q <= idx_d;
         scan_end_q <= run_i && tick_i && (phase_q == PH_SCAN);
      end
   end

   assign phase_o = phase_q;
   assign com_idx_o = idx_q;
   assign scan_end_o = scan_end_q;

endmodule

/* File: lcd_drive_mode_control.sv */
// Drive-setup and display-control registers with slice and key-scan logic
`timescale 1ns/1ps
module lcd_drive_mode_control
   import lcd_ctrl_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire cpu_wr_s cpu_wr_i,
   input wire logic [15:0] cpu_rd_addr_i,
   output logic [7:0] cpu_rd_data_o,
   input wire logic slice_tick_i,
   input wire logic [4:0] key_return_i,
   output panel_ctrl_s panel_o,
   output logic [7:0] common_sel_o,
   output logic [7:0] key_source_o,
   output logic [4:0] key_data_o,
   output logic key_data_valid_o
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0] drive_setup_q;
   logic [7:0] display_control_q;
   logic [2:0] tick_sync_q;
   logic [4:0] kr_meta_q;
   logic [4:0] kr_sync_q;
   logic [4:0] key_data_q;
   logic key_valid_q;
   logic [7:0] common_q;
   logic [7:0] key_source_q;

   wire logic hit_drive = (cpu_wr_i.addr == DRIVE_SETUP_ADDR);
   wire logic hit_display = (cpu_wr_i.addr == DISPLAY_CONTROL_ADDR);
   wire logic [7:0] drive_setup_d = wr_merge(drive_setup_q, cpu_wr_i, DRIVE_SETUP_WMASK);
   wire logic [7:0] display_control_d =
      wr_merge(display_control_q, cpu_wr_i, DISPLAY_CONTROL_WMASK);

   // Unused bits are never stored, so they read zero whatever is written, except drive-setup bit 1, which reads the scan flag
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         drive_setup_q <= DRIVE_SETUP_RESET;
         display_control_q <= DISPLAY_CONTROL_RESET;
      end else begin
         if (hit_drive) begin
            drive_setup_q <= drive_setup_d;
         end
         if (hit_display) begin
            display_control_q <= display_control_d;
         end
      end
   end

   // ---------------------------------------------------------------
   // Field decode
   // ---------------------------------------------------------------
   wire logic key_scan_enable = drive_setup_q[KEY_SCAN_ENABLE_BIT];
   wire logic [1:0] vgen_sel = drive_setup_q[VGEN_SEL_HI_BIT:VGEN_SEL_LO_BIT];
   wire logic display_enable = display_control_q[DISPLAY_ENABLE_BIT];
   wire logic pin_output_control = display_control_q[PIN_OUTPUT_CONTROL_BIT];
   wire logic gate_boost_enable = display_control_q[GATE_BOOST_ENABLE_BIT];
   wire logic [2:0] display_mode_sel = display_control_q[MODE_SEL_MSB:MODE_SEL_LSB];
   wire logic [3:0] slices = mode_slices(display_mode_sel);
   wire logic mode_valid = (slices != SLICES_NONE);
   wire logic quarter_bias = (display_mode_sel == MODE_8_QUARTER);
   wire logic static_mode = (display_mode_sel == MODE_STATIC);
   // Prohibited mode codes stop the sequencer rather than guess a waveform
   wire logic seq_run = pin_output_control && mode_valid;
   wire logic scan_allowed = key_scan_enable && !static_mode;

   // ---------------------------------------------------------------
   // Pin-side synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tick_sync_q <= 3'h0;
         kr_meta_q <= 5'h00;
         kr_sync_q <= 5'h00;
      end else begin
         tick_sync_q <= {tick_sync_q[1:0], slice_tick_i};
         kr_meta_q <= key_return_i;
         kr_sync_q <= kr_meta_q;
      end
   end

   wire logic tick_pulse = tick_sync_q[1] && !tick_sync_q[2];

   // ---------------------------------------------------------------
   // Slice sequencing
   // ---------------------------------------------------------------
   slice_phase_e phase;
   logic [2:0] com_idx;
   logic scan_end;

   lcd_slice_sequencer u_seq (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .tick_i(tick_pulse),
      .run_i(seq_run),
      .slices_i(slices),
      .scan_en_i(scan_allowed),
      .phase_o(phase),
      .com_idx_o(com_idx),
      .scan_end_o(scan_end)
   );

   wire logic in_scan = (phase == PH_SCAN);
   wire logic [7:0] com_onehot = 8'h01 << com_idx;
   // Upper commons are alternate-function pins outside eight-slice mode
   wire logic [7:0] com_mask = quarter_bias ? 8'hff : 8'h0f;
   wire logic [7:0] common_d = (phase == PH_DISP) ? (com_onehot & com_mask) : 8'h00;
   // Return 0 shares its pin with the third reference in quarter bias
   wire logic [4:0] kr_enable = quarter_bias ? 5'h1e : 5'h1f;

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         common_q <= 8'h00;
         key_source_q <= 8'h00;
         key_data_q <= 5'h00;
         key_valid_q <= 1'b0;
      end else begin
         common_q <= common_d;
         key_source_q <= in_scan ? KEY_SOURCE_ALL : 8'h00;
         key_valid_q <= scan_end;
         if (scan_end) begin
            key_data_q <= kr_sync_q & kr_enable;
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs and read-back
   // ---------------------------------------------------------------
   always_comb begin
      panel_o.pins_grounded = !pin_output_control;
      panel_o.seg_deselect = !display_enable || !pin_output_control;
      panel_o.gate_boost_enable = gate_boost_enable;
      panel_o.vgen_sel = vgen_sel;
      panel_o.vgen_valid = (vgen_sel != 2'h2);
      panel_o.bias = mode_bias(display_mode_sel);
      panel_o.mode_valid = mode_valid;
      panel_o.ref3_select = quarter_bias;
      panel_o.com_hi_is_common = quarter_bias;
   end

   assign common_sel_o = common_q;
   assign key_source_o = key_source_q;
   assign key_data_o = key_data_q;
   assign key_data_valid_o = key_valid_q;

   wire logic [7:0] drive_readback = drive_setup_q | {6'h00, in_scan, 1'b0};
   assign cpu_rd_data_o = (cpu_rd_addr_i == DRIVE_SETUP_ADDR) ? drive_readback :
                          (cpu_rd_addr_i == DISPLAY_CONTROL_ADDR) ? display_control_q :
                          8'h00;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_drive_byte_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (hit_drive && cpu_wr_i.byte_we) |=> drive_setup_q == ($past(cpu_wr_i.wdata) & 8'h31))
      else $error("drive-setup byte write not stored");
   a_display_bit_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (hit_display && !cpu_wr_i.byte_we && cpu_wr_i.bit_we && cpu_wr_i.bit_idx == 3'h7)
      |=> display_enable == $past(cpu_wr_i.bit_val))
      else $error("display-control bit write not stored");
   a_scan_flag_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (cpu_rd_addr_i == DRIVE_SETUP_ADDR)
      |=> key_source_o == ($past(cpu_rd_data_o[1]) ? 8'hff : 8'h00))
      else $error("scan flag does not follow scan slice");
   a_scan_off_stays: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (!key_scan_enable && !in_scan) |=> !in_scan)
      else $error("scan slice entered with scan disabled");
   a_scan_single_slice: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (in_scan && tick_pulse && seq_run) |=> !in_scan ##1 key_data_valid_o)
      else $error("scan slice did not end with a sample");
   // Commons lag the control bit by two cycles through the sequencer
   a_ground_pins: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (!pin_output_control && !$past(pin_output_control))
      |-> panel_o.pins_grounded ##1 common_sel_o == 8'h00)
      else $error("pins not grounded with output control low");
   a_deselect_off: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $fell(display_enable) |-> panel_o.seg_deselect)
      else $error("segments not deselected with display off");
   a_com_hi_gated: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !$past(quarter_bias) |-> common_sel_o[7:4] == 4'h0)
      else $error("upper common driven outside eight-slice mode");
   a_ref3_kr0_mask: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (key_data_valid_o && $past(quarter_bias)) |-> key_data_o[0] == 1'b0)
      else $error("return 0 sampled while used as reference");

endmodule

/* File: key_matrix_model.sv */
// Behavioural segment key matrix on the far side of the key-scan pins
`timescale 1ns/1ps
module key_matrix_model (
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   input wire logic [7:0] key_source_i,
   input wire logic [4:0] pressed_i,
   output logic [4:0] key_return_o
);
   // ---------------------------------------------------------------
   // Return lines
   // ---------------------------------------------------------------
   // Outside the scan slice nothing drives the returns: toggle so that a
   // sample taken at the wrong time cannot match by luck
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         key_return_o <= 5'h00;
      end else if (key_source_i != 8'h00) begin
         key_return_o <= pressed_i;
      end else begin
         key_return_o <= ~key_return_o;
      end
   end
endmodule

/* File: tb_lcd_drive_mode_control.sv */
// Self-checking testbench for the LCD drive-mode control registers
`timescale 1ns/1ps
module tb_lcd_drive_mode_control;
   import lcd_ctrl_pkg::*;
   logic clk_sys_i;
   logic rstn_i;
   cpu_wr_s wr;
   logic [15:0] rd_addr;
   logic [7:0] rd_data;
   logic tick;
   logic [4:0] key_return;
   logic [4:0] pressed;
   panel_ctrl_s panel;
   logic [7:0] common_sel;
   logic [7:0] key_source;
   logic [4:0] key_data;
   logic key_valid;
   int failures = 0;
   int samples_checked = 0;
   int pulses = 0;
   int p;
   logic [2:0] modes [6] = '{3'h7, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
   int slices [6] = '{8, 4, 3, 2, 3, 1};

   // ---------------------------------------------------------------
   // Instances
   // ---------------------------------------------------------------
   lcd_drive_mode_control u_lcd_drive_mode_control (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .cpu_wr_i(wr),
      .cpu_rd_addr_i(rd_addr),
      .cpu_rd_data_o(rd_data),
      .slice_tick_i(tick),
      .key_return_i(key_return),
      .panel_o(panel),
      .common_sel_o(common_sel),
      .key_source_o(key_source),
      .key_data_o(key_data),
      .key_data_valid_o(key_valid)
   );
   key_matrix_model u_key_matrix_model (
      .clk_sys_i(clk_sys_i),
      .rstn_i(rstn_i),
      .key_source_i(key_source),
      .pressed_i(pressed),
      .key_return_o(key_return)
   );

   // ---------------------------------------------------------------
   // Clock, monitor and tasks
   // ---------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end

   // Valid is a one-cycle pulse, so count it rather than sample it
   always @(posedge clk_sys_i) begin
      if (key_valid === 1'b1) begin
         pulses <= pulses + 1;
      end
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr_any(input logic [15:0] a, input logic bw, input logic [2:0] idx,
                         input logic [7:0] d);
      @(posedge clk_sys_i);
      wr <= '{addr: a, byte_we: bw, bit_we: ~bw, bit_idx: idx, bit_val: d[0], wdata: d};
      @(posedge clk_sys_i);
      wr <= '0;
      #1;
   endtask

   task automatic rd_check(input string what, input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      rd_addr <= a;
      @(posedge clk_sys_i);
      #1;
      check(what, rd_data, exp);
   endtask

   // Ticks spaced well beyond the 4-cycle minimum; result settled 8 cycles on
   task automatic tick_check(input logic [7:0] com, input logic [7:0] src);
      @(posedge clk_sys_i);
      tick <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      tick <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      #1;
      check("common_sel", common_sel, com);
      check("key_source", key_source, src);
   endtask

   initial begin
      #400000;
      failures++;
      $display("ERROR watchdog expected 00 seen 01");
      summarize();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      wr = '0;
      rd_addr = 16'h0000;
      tick = 1'b0;
      pressed = 5'h00;
      rstn_i = 1'b0;
      repeat (4) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      rd_check("drive_setup", DRIVE_SETUP_ADDR, 8'h00);
      rd_check("display_ctrl", DISPLAY_CONTROL_ADDR, 8'h00);
      check("ground_desel", {6'h00, panel.pins_grounded, panel.seg_deselect}, 8'h03);
      $display("test reset finished");

      wr_any(DRIVE_SETUP_ADDR, 1'b1, 3'h0, 8'h37);
      rd_check("drive_setup", DRIVE_SETUP_ADDR, 8'h31);
      wr_any(DRIVE_SETUP_ADDR, 1'b0, 3'h5, 8'h00);
      rd_check("drive_setup", DRIVE_SETUP_ADDR, 8'h11);
      for (int i = 0; i < 4; i++) begin
         wr_any(DRIVE_SETUP_ADDR, 1'b1, 3'h0, 8'(i << 4));
         check("vgen", {5'h00, panel.vgen_valid, panel.vgen_sel},
               {5'h00, 1'(i != 2), i[1:0]});
      end
      wr_any(16'hffb2, 1'b1, 3'h0, 8'hff);
      rd_check("unmapped", 16'hffb2, 8'h00);
      rd_check("display_ctrl", DISPLAY_CONTROL_ADDR, 8'h00);
      wr_any(DISPLAY_CONTROL_ADDR, 1'b1, 3'h0, 8'hd7);
      rd_check("display_ctrl", DISPLAY_CONTROL_ADDR, 8'hd7);
      wr_any(DISPLAY_CONTROL_ADDR, 1'b0, 3'h7, 8'h00);
      rd_check("display_ctrl", DISPLAY_CONTROL_ADDR, 8'h57);
      for (int i = 0; i < 8; i++) begin
         wr_any(DISPLAY_CONTROL_ADDR, 1'b1, 3'h0, {i[2], i[1], 1'b0, i[0], 4'h0});
         // Grounded pins also count as deselected segments
         check("gnd_desel_boost", {5'h00, panel.pins_grounded,
               panel.seg_deselect, panel.gate_boost_enable},
               {5'h00, ~i[1], ~(i[2] & i[1]), i[0]});
      end
      for (int i = 0; i < 8; i++) begin
         wr_any(DISPLAY_CONTROL_ADDR, 1'b1, 3'h0, 8'h40 | 8'(i));
         check("valid_ref3_comhi", {5'h00, panel.mode_valid,
               panel.ref3_select, panel.com_hi_is_common},
               {5'h00, 1'(i < 5 || i == 7), 1'(i == 7), 1'(i == 7)});
         if (i < 5 || i == 7) begin
            check("bias", 8'(panel.bias), (i == 7) ? 8'h03 : (i < 2) ? 8'h02 :
                  (i < 4) ? 8'h01 : 8'h00);
         end
      end
      // First tick out of idle enters display slice 0
      tick_check(8'h01, 8'h00);
      $display("test registers finished");

      wr_any(DRIVE_SETUP_ADDR, 1'b1, 3'h0, 8'h01);
      for (int m = 0; m < 6; m++) begin
         pressed <= 5'(m * 5 + 3);
         wr_any(DISPLAY_CONTROL_ADDR, 1'b1, 3'h0, 8'h00);
         repeat (3) @(posedge clk_sys_i);
         #1;
         check("common_sel", common_sel, 8'h00);
         wr_any(DISPLAY_CONTROL_ADDR, 1'b1, 3'h0, 8'h40 | 8'(modes[m]));
         for (int s = 0; s < slices[m]; s++) begin
            tick_check(8'h01 << s, 8'h00);
         end
         if (modes[m] == MODE_STATIC) begin
            tick_check(8'h01, 8'h00);
         end else begin
            tick_check(8'h00, 8'hff);
            rd_check("scan_flag", DRIVE_SETUP_ADDR, 8'h03);
            p = pulses;
            tick_check(8'h01, 8'h00);
            check("valid_pulses", 8'(pulses - p), 8'h01);
            check("key_data", {3'h0, key_data},
                  {3'h0, pressed & ((modes[m] == MODE_8_QUARTER) ? 5'h1e : 5'h1f)});
            rd_check("scan_flag", DRIVE_SETUP_ADDR, 8'h01);
         end
      end
      $display("test scan frames finished");

      wr_any(DRIVE_SETUP_ADDR, 1'b1, 3'h0, 8'h00);
      wr_any(DISPLAY_CONTROL_ADDR, 1'b1, 3'h0, 8'h00);
      wr_any(DISPLAY_CONTROL_ADDR, 1'b1, 3'h0, 8'h42);
      tick_check(8'h01, 8'h00);
      tick_check(8'h02, 8'h00);
      tick_check(8'h01, 8'h00);
      wr_any(DISPLAY_CONTROL_ADDR, 1'b1, 3'h0, 8'h00);
      check("grounded", {7'h00, panel.pins_grounded}, 8'h01);
      $display("test scan off finished");
      summarize();
   end
endmodule
